// ### verilog/muxed_flash_psram_bus_port.sv
// Device-side logic of the shared flash and pseudo-static RAM multiplexed pin port.
`timescale 1ns/1ps
`include "mcp_defines.svh"
module muxed_flash_psram_bus_port #(
    parameter int MEM_AW = `MEM_AW,
    parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic burst_mode,
    input wire logic flash_ready_active_high,
    input wire logic [`DQ_W-1:0] shared_addr_data_lines,
    output logic [`DQ_W-1:0] dq_out,
    output logic [1:0] dq_oe_n,
    input wire logic [`UA_W-1:0] upper_address_lines,
    input wire logic address_valid_strobe_n,
    input wire logic output_enable_n,
    input wire logic write_enable_n,
    input wire logic burst_clk,
    input wire logic flash_ce_n,
    input wire logic psram_ce_n,
    input wire logic flash_reset_n,
    input wire logic flash_write_protect_n,
    input wire logic [1:0] flash_program_accel,
    input wire logic psram_cfg_reg_select,
    input wire logic psram_upper_byte_sel_n,
    input wire logic psram_lower_byte_sel_n,
    output logic ready_wait,
    output logic ready_wait_oe_n,
    output logic flash_busy,
    output logic flash_program_refused,
    output logic flash_unlock_bypass,
    output logic psram_wait_active_high
);
    localparam int DEPTH = 2 ** MEM_AW;
    localparam int NSECT = DEPTH >> `SECTOR_SHIFT;

    // ***************************************************************
    // Pin synchronisers
    // ***************************************************************
    mcp_pkg::pins_s pins, s1, s2, prev;

    assign pins = {shared_addr_data_lines, upper_address_lines, address_valid_strobe_n,
                   output_enable_n, write_enable_n, burst_clk, flash_ce_n, psram_ce_n,
                   flash_reset_n, flash_write_protect_n, flash_program_accel,
                   psram_cfg_reg_select, psram_upper_byte_sel_n, psram_lower_byte_sel_n};

    // Every active-low pin settles deasserted while reset is held.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            s1 <= '1;
            s2 <= '1;
            prev <= '1;
        end else begin
            s1 <= pins;
            s2 <= s1;
            prev <= s2;
        end
    end

    logic flash_sel, psram_sel, any_sel, avd_low, clk_rise, we_rise, start;
    assign flash_sel = !s2.flash_ce_n;
    assign psram_sel = !s2.psram_ce_n && s2.flash_ce_n;
    assign any_sel = flash_sel || psram_sel;
    assign avd_low = !s2.avd_n;
    assign clk_rise = s2.clk && !prev.clk;
    assign we_rise = s2.we_n && !prev.we_n;
    assign start = burst_mode && avd_low && any_sel;

    function automatic logic [MEM_AW-1:0] word_index(input logic [`DQ_W-1:0] a);
        return a[MEM_AW-1:0];
    endfunction

    function automatic logic is_outer(input logic [MEM_AW-1:0] idx);
        int sec;
        sec = int'(idx) >> `SECTOR_SHIFT;
        return (sec < `OUTER_PER_END) || (sec >= NSECT - `OUTER_PER_END);
    endfunction

    // ***************************************************************
    // Storage
    // ***************************************************************
    logic [`DQ_W-1:0] flash_mem [DEPTH];
    logic [`DQ_W-1:0] psram_mem [DEPTH];
    logic [`DQ_W-1:0] psram_cfg;
    logic [`DQ_W+`UA_W-1:0] addr, next_addr;

    function automatic logic [`DQ_W-1:0] read_word(input logic [MEM_AW-1:0] idx);
        if (flash_sel) begin
            return flash_mem[idx];
        end
        return s2.cre ? psram_cfg : psram_mem[idx];
    endfunction

    // ***************************************************************
    // Address capture and burst engine
    // ***************************************************************
    mcp_pkg::burst_e state, next_state;
    logic [MEM_AW-1:0] cnt, next_cnt;
    logic data_valid, next_valid;
    logic [`DQ_W-1:0] next_dout;
    logic fifo_push, fifo_pop, fifo_flush, fifo_in_ready, fifo_out_valid;
    logic [`DQ_W-1:0] fifo_out_data;

    always_comb begin
        next_addr = addr;
        next_state = state;
        next_cnt = cnt;
        next_valid = data_valid;
        next_dout = dq_out;
        fifo_push = 1'b0;
        fifo_pop = 1'b0;
        fifo_flush = 1'b0;
        if (avd_low && any_sel) begin
            next_addr = {s2.upper, s2.dq};
        end
        unique case (state)
            mcp_pkg::BURST_IDLE: begin
                if (!burst_mode && any_sel) begin
                    next_dout = read_word(word_index(addr[`DQ_W-1:0]));
                    next_valid = 1'b1;
                end
            end
            mcp_pkg::BURST_FIRST: begin
                if (fifo_out_valid) begin
                    fifo_pop = 1'b1;
                    next_dout = fifo_out_data;
                    next_valid = 1'b1;
                    next_state = mcp_pkg::BURST_RUN;
                end
            end
            mcp_pkg::BURST_RUN: begin
                if (clk_rise) begin
                    fifo_pop = fifo_out_valid;
                    next_valid = fifo_out_valid;
                    if (fifo_out_valid) begin
                        next_dout = fifo_out_data;
                    end
                end
            end
        endcase
        if (state != mcp_pkg::BURST_IDLE && fifo_in_ready) begin
            fifo_push = 1'b1;
            next_cnt = MEM_AW'(cnt + 1'b1);
        end
        if (!any_sel || (flash_sel && !s2.flash_rst_n)) begin
            next_state = mcp_pkg::BURST_IDLE;
            fifo_flush = 1'b1;
            fifo_push = 1'b0;
            next_valid = 1'b0;
        end else if (start) begin
            next_state = mcp_pkg::BURST_FIRST;
            next_cnt = word_index(s2.dq);
            fifo_flush = 1'b1;
            fifo_push = 1'b0;
            next_valid = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            addr <= '0;
            state <= mcp_pkg::BURST_IDLE;
            cnt <= '0;
            data_valid <= 1'b0;
            dq_out <= '0;
        end else begin
            addr <= next_addr;
            state <= next_state;
            cnt <= next_cnt;
            data_valid <= next_valid;
            dq_out <= next_dout;
        end
    end

    word_fifo #(
        .W(`DQ_W),
        .DEPTH(FIFO_DEPTH)
    ) u_burst_fifo (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .flush(fifo_flush),
        .in_valid(fifo_push),
        .in_ready(fifo_in_ready),
        .in_data(read_word(cnt)),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_out_data)
    );

    // ***************************************************************
    // Flash programming and RAM writes
    // ***************************************************************
    mcp_pkg::flash_e fstate, next_fstate;
    logic [`PROG_CNT_W-1:0] pcnt, next_pcnt;
    logic [MEM_AW-1:0] pidx, next_pidx, widx;
    logic [`DQ_W-1:0] pdata, next_pdata, next_cfg;
    logic [`DQ_W-1:0] next_flash_mem [DEPTH];
    logic [`DQ_W-1:0] next_psram_mem [DEPTH];
    logic next_refused, flash_wr, psram_wr;

    assign widx = word_index(addr[`DQ_W-1:0]);
    assign flash_wr = we_rise && flash_sel;
    assign psram_wr = we_rise && psram_sel;

    always_comb begin
        next_fstate = fstate;
        next_pcnt = pcnt;
        next_pidx = pidx;
        next_pdata = pdata;
        next_refused = 1'b0;
        next_flash_mem = flash_mem;
        next_psram_mem = psram_mem;
        next_cfg = psram_cfg;
        if (!s2.flash_rst_n) begin
            next_fstate = mcp_pkg::FLASH_READ_ARRAY;
            next_pcnt = '0;
        end else begin
            unique case (fstate)
                mcp_pkg::FLASH_READ_ARRAY: begin
                    if (flash_wr) begin
                        if (s2.accel == `ACC_VIL || (!s2.flash_wp_n && is_outer(widx))) begin
                            next_refused = 1'b1;
                        end else begin
                            next_fstate = mcp_pkg::FLASH_PROGRAM;
                            next_pidx = widx;
                            next_pdata = prev.dq;
                            next_pcnt = (s2.accel == `ACC_VHH) ?
                                `PROG_CNT_W'(`ACCEL_PROG_CYCLES) :
                                `PROG_CNT_W'(`PROG_CYCLES);
                        end
                    end
                end
                mcp_pkg::FLASH_PROGRAM: begin
                    if (pcnt <= `PROG_CNT_W'(1)) begin
                        next_flash_mem[pidx] = flash_mem[pidx] & pdata;
                        next_fstate = mcp_pkg::FLASH_READ_ARRAY;
                        next_pcnt = '0;
                    end else begin
                        next_pcnt = `PROG_CNT_W'(pcnt - 1'b1);
                    end
                end
            endcase
        end
        if (psram_wr) begin
            if (prev.cre) begin
                next_cfg = prev.dq;
            end else begin
                if (!prev.ub_n) begin
                    next_psram_mem[widx][15:8] = prev.dq[15:8];
                end
                if (!prev.lb_n) begin
                    next_psram_mem[widx][7:0] = prev.dq[7:0];
                end
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            fstate <= mcp_pkg::FLASH_READ_ARRAY;
            pcnt <= '0;
            pidx <= '0;
            pdata <= '0;
            psram_cfg <= `PSRAM_CFG_RST;
            flash_mem <= '{default: `ERASED_WORD};
            psram_mem <= '{default: '0};
        end else begin
            fstate <= next_fstate;
            pcnt <= next_pcnt;
            pidx <= next_pidx;
            pdata <= next_pdata;
            psram_cfg <= next_cfg;
            flash_mem <= next_flash_mem;
            psram_mem <= next_psram_mem;
        end
    end

    // ***************************************************************
    // Pin drivers
    // ***************************************************************
    logic [1:0] next_oe_n;
    logic rd_en, vld, next_ready, next_ready_oe_n, src_flash;

    always_comb begin
        rd_en = !s2.oe_n && s2.we_n && s2.avd_n;
        next_oe_n[1] = !(rd_en && (flash_sel || (psram_sel && !s2.ub_n)));
        next_oe_n[0] = !(rd_en && (flash_sel || (psram_sel && !s2.lb_n)));
        vld = burst_mode ? next_valid : 1'b1;
        if (flash_sel) begin
            next_ready = flash_ready_active_high ? vld : !vld;
        end else begin
            next_ready = psram_cfg[`POL_BIT] ? !vld : vld;
        end
        next_ready_oe_n = !any_sel;
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            dq_oe_n <= 2'h3;
            ready_wait <= 1'b0;
            ready_wait_oe_n <= 1'b1;
            src_flash <= 1'b0;
            flash_busy <= 1'b0;
            flash_program_refused <= 1'b0;
            flash_unlock_bypass <= 1'b0;
            psram_wait_active_high <= 1'b1;
        end else begin
            dq_oe_n <= next_oe_n;
            ready_wait <= next_ready;
            ready_wait_oe_n <= next_ready_oe_n;
            src_flash <= flash_sel;
            flash_busy <= next_fstate == mcp_pkg::FLASH_PROGRAM;
            flash_program_refused <= next_refused;
            flash_unlock_bypass <= s2.accel == `ACC_VHH;
            psram_wait_active_high <= next_cfg[`POL_BIT];
        end
    end

    // ***************************************************************
    // Checks
    // ***************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    sequence s_run_edge;
        state == mcp_pkg::BURST_RUN && clk_rise && fifo_out_valid && any_sel && !start &&
        !(flash_sel && !s2.flash_rst_n);
    endsequence

    sequence s_refused_write;
        fstate == mcp_pkg::FLASH_READ_ARRAY && flash_wr && s2.flash_rst_n;
    endsequence

    chk_oe_release: assert property ($rose(s2.oe_n) |=> dq_oe_n == 2'h3)
        else $error("data drive kept after output enable released");
    chk_flash_ready: assert property (src_flash && !ready_wait_oe_n |->
        ready_wait == ($past(flash_ready_active_high) ? (data_valid || !$past(burst_mode))
        : !(data_valid || !$past(burst_mode))))
        else $error("flash ready polarity wrong");
    chk_psram_wait: assert property (!src_flash && !ready_wait_oe_n &&
        $past(burst_mode) |->
        ready_wait == ($past(psram_cfg[`POL_BIT]) ? !data_valid : data_valid))
        else $error("ram wait polarity wrong");
    chk_burst_advance: assert property (s_run_edge |=> data_valid &&
        dq_out == $past(fifo_out_data))
        else $error("burst word not advanced on clock edge");
    chk_addr_latch: assert property (avd_low && any_sel |=>
        addr == $past({s2.upper, s2.dq}))
        else $error("address not captured while strobe low");
    chk_addr_hold: assert property (s2.avd_n |=> $stable(addr))
        else $error("address changed while strobe high");
    chk_flash_reset: assert property (!s2.flash_rst_n |=>
        fstate == mcp_pkg::FLASH_READ_ARRAY && !flash_busy)
        else $error("flash did not return to array read");
    chk_protect_refuse: assert property (s_refused_write ##0
        (!s2.flash_wp_n && is_outer(widx)) |=> flash_program_refused && !flash_busy)
        else $error("protected sector program not refused");
    chk_accel_block: assert property (s_refused_write ##0
        (s2.accel == `ACC_VIL) |=> flash_program_refused ##1 !flash_busy)
        else $error("program not blocked with accelerate low");
    chk_ce_deselect: assert property (s2.flash_ce_n && s2.psram_ce_n |=>
        dq_oe_n == 2'h3 && ready_wait_oe_n)
        else $error("pins driven with no chip enable");
    chk_byte_gate: assert property (psram_sel && s2.ub_n |=> dq_oe_n[1])
        else $error("upper byte driven while deselected");
endmodule // muxed_flash_psram_bus_port

// ### verilog/mcp_defines.svh
// Constants for the shared flash and pseudo-static RAM pin port.
// Functional notes
// - Output drive follows the output enable pin without waiting for a burst clock edge.
// - Flash ready, active-high default: low while burst data invalid, high while valid.
// - RAM wait, default setting: high while data invalid, low while valid.
// - After the first burst word, each rising burst clock edge advances and presents next.
// - Strobe low: address valid asynchronously, latched as burst start address in burst.
// - Strobe high: address inputs ignored, captured address kept.
// - Flash reset pin low returns the flash to reading array data.
// - Write protect low refuses program in the four outermost flash sectors.
// - High accelerate voltage speeds programming, sets unlock bypass; low blocks it.
// - Each die answers to its own chip enable; with both chip enables low only the flash answers.
// - Upper and lower byte selects gate their halves of the RAM data word.
`ifndef MCP_DEFINES_SVH
`define MCP_DEFINES_SVH

`define DQ_W 16
`define UA_W 7
`define MEM_AW 4
`define POL_BIT 10
`define PSRAM_CFG_RST 16'h0400
`define ERASED_WORD 16'hffff
`define SECTOR_SHIFT 1
`define OUTER_PER_END 2
`define ACC_VIL 2'h0
`define ACC_VHH 2'h3
`define CLK_PERIOD_NS 100
`define PROG_TIME_NS 400
`define ACCEL_PROG_TIME_NS 200
`define PROG_CYCLES ((`PROG_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ACCEL_PROG_CYCLES ((`ACCEL_PROG_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PROG_CNT_W 3
`define FIFO_DEPTH 4

`endif

// ### verilog/mcp_pkg.sv
// Types used by the pin port: its pin bundle and its state encodings.
package mcp_pkg;
`include "mcp_defines.svh"

    typedef struct packed {
        logic [`DQ_W-1:0] dq;
        logic [`UA_W-1:0] upper;
        logic avd_n;
        logic oe_n;
        logic we_n;
        logic clk;
        logic flash_ce_n;
        logic psram_ce_n;
        logic flash_rst_n;
        logic flash_wp_n;
        logic [1:0] accel;
        logic cre;
        logic ub_n;
        logic lb_n;
    } pins_s;

    typedef enum logic [2:0] {
        BURST_IDLE = 3'b001,
        BURST_FIRST = 3'b010,
        BURST_RUN = 3'b100
    } burst_e;

    typedef enum logic [1:0] {
        FLASH_READ_ARRAY = 2'b01,
        FLASH_PROGRAM = 2'b10
    } flash_e;

endpackage

// ### verilog/word_fifo.sv
// Small word buffer between the array read side and the burst output.
`timescale 1ns/1ps
module word_fifo #(
    parameter int W = 16,
    parameter int DEPTH = 4
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic flush,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem [DEPTH];
    logic [W-1:0] next_mem [DEPTH];
    logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
    logic [AW:0] count, next_count;
    logic do_push, do_pop;

    always_comb begin
        do_push = in_valid && in_ready;
        do_pop = out_valid && out_ready;
        next_mem = mem;
        next_wr_ptr = wr_ptr;
        next_rd_ptr = rd_ptr;
        next_count = count;
        if (flush) begin
            next_wr_ptr = '0;
            next_rd_ptr = '0;
            next_count = '0;
        end else begin
            if (do_push) begin
                next_mem[wr_ptr] = in_data;
                next_wr_ptr = (int'(wr_ptr) == DEPTH - 1) ? '0 : AW'(wr_ptr + 1'b1);
            end
            if (do_pop) begin
                next_rd_ptr = (int'(rd_ptr) == DEPTH - 1) ? '0 : AW'(rd_ptr + 1'b1);
            end
            next_count = (AW+1)'(count + (AW+1)'(do_push) - (AW+1)'(do_pop));
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
        end
    end

    always_ff @(posedge ref_clk) begin
        mem <= next_mem;
    end

    assign in_ready = int'(count) < DEPTH;
    assign out_valid = count != '0;
    assign out_data = mem[rd_ptr];
endmodule // word_fifo

// ### testbench/host_model.sv
// Host memory controller model that drives the shared pin port.
`timescale 1ns/1ps
`include "mcp_defines.svh"
module host_model (
    input wire logic ref_clk,
    output logic [`DQ_W-1:0] dq,
    output logic [`UA_W-1:0] upper,
    output logic avd_n,
    output logic oe_n,
    output logic we_n,
    output logic bclk,
    output logic fce_n,
    output logic rce_n,
    output logic cre,
    output logic ub_n,
    output logic lb_n
);
    initial begin
        {dq, upper, cre, ub_n, lb_n, bclk} = '0;
        {avd_n, oe_n, we_n, fce_n, rce_n} = 5'h1f;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    // Only one die is selected per access, so the two never share the bus.
    task automatic addr(input logic r, input logic [3:0] a);
        fce_n = r;
        rce_n = !r;
        dq = {12'h000, a};
        avd_n = 1'b0;
        cyc(4);
        avd_n = 1'b1;
        dq = ~dq;
        cyc(1);
    endtask
    task automatic done();
        {fce_n, rce_n, oe_n} = 3'h7;
        {cre, ub_n, lb_n} = 3'h0;
        dq = ~dq;
        cyc(4);
    endtask
    task automatic write(input logic r, input logic [3:0] a, input logic [15:0] d,
                         input logic u, input logic l, input logic c);
        addr(r, a);
        {dq, ub_n, lb_n, cre} = {d, u, l, c};
        cyc(1);
        we_n = 1'b0;
        cyc(4);
        we_n = 1'b1;
        cyc(4);
        done();
    endtask
    task automatic read(input logic r, input logic [3:0] a);
        addr(r, a);
        oe_n = 1'b0;
        cyc(8);
    endtask
    // The burst clock only moves inside a burst and rests low otherwise.
    task automatic pulse();
        bclk = 1'b1;
        cyc(4);
        bclk = 1'b0;
        cyc(4);
    endtask
endmodule // host_model

// ### testbench/tb.sv
// Self-checking bench for the shared flash and pseudo-static RAM pin port.
`timescale 1ns/1ps
`include "mcp_defines.svh"
module tb;
    logic ref_clk, rst_b, burst_mode, pol_hi, rst_f_n, wp_n;
    logic [1:0] accel, dq_oe_n;
    logic [`DQ_W-1:0] h_dq, dq_out, d;
    logic [`UA_W-1:0] h_up;
    logic avd_n, oe_n, we_n, bclk, fce_n, rce_n, cre, ub_n, lb_n;
    logic rdy, rdy_oe_n, busy, refused, bypass, pwait_hi;
    logic [`DQ_W-1:0] flash_m [16];
    logic [`DQ_W-1:0] ram_m [16];
    logic [3:0] wp_list [6] = '{4'h1, 4'h3, 4'h4, 4'hb, 4'hc, 4'he};
    logic [31:0] seed;
    int n_errors, comparisons, cycles, n_ref, exp_ref, run, last_busy;

    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    host_model host (.ref_clk(ref_clk), .dq(h_dq), .upper(h_up), .avd_n(avd_n), .oe_n(oe_n),
        .we_n(we_n), .bclk(bclk), .fce_n(fce_n), .rce_n(rce_n), .cre(cre), .ub_n(ub_n),
        .lb_n(lb_n));

    muxed_flash_psram_bus_port dut (.ref_clk(ref_clk), .rst_b(rst_b),
        .burst_mode(burst_mode), .flash_ready_active_high(pol_hi),
        .shared_addr_data_lines(h_dq), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
        .upper_address_lines(h_up), .address_valid_strobe_n(avd_n), .output_enable_n(oe_n),
        .write_enable_n(we_n), .burst_clk(bclk), .flash_ce_n(fce_n), .psram_ce_n(rce_n),
        .flash_reset_n(rst_f_n), .flash_write_protect_n(wp_n), .flash_program_accel(accel),
        .psram_cfg_reg_select(cre), .psram_upper_byte_sel_n(ub_n),
        .psram_lower_byte_sel_n(lb_n), .ready_wait(rdy), .ready_wait_oe_n(rdy_oe_n),
        .flash_busy(busy), .flash_program_refused(refused), .flash_unlock_bypass(bypass),
        .psram_wait_active_high(pwait_hi));

    // ****************************************
    // Helpers and monitors
    // ****************************************
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic close_out();
        $display("comparisons=%0d n_errors=%0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Refusal pulses last one cycle and busy length is measured on its fall.
    always @(posedge ref_clk) begin
        cycles++;
        if (refused === 1'b1) n_ref++;
        if (busy === 1'b1) begin
            run++;
        end else if (run != 0) begin
            last_busy = run;
            run = 0;
        end
        if (cycles == 10000) begin
            n_errors++;
            close_out();
        end
    end
    task automatic verify_all(input logic r);
        for (int i = 0; i < 16; i++) begin
            host.read(r, 4'(i));
            check(dq_out, r ? ram_m[i] : flash_m[i]);
            check({13'h0, dq_oe_n, rdy_oe_n}, 16'h0);
            host.done();
            check({14'h0, dq_oe_n}, 16'h3);
        end
    endtask
    task automatic prog(input logic [3:0] a, input logic [15:0] v);
        logic refuse;
        refuse = accel == `ACC_VIL || (!wp_n && (a < 4'h4 || a > 4'hb));
        host.write(1'b0, a, v, 1'b0, 1'b0, 1'b0);
        host.cyc(8);
        if (!refuse) flash_m[a] = flash_m[a] & v;
        exp_ref += int'(refuse);
        check(16'(n_ref), 16'(exp_ref));
    endtask
    task automatic burst(input logic r, input logic [3:0] a, input logic valid_lvl);
        burst_mode = 1'b1;
        host.read(r, a);
        for (int k = 0; k < 4; k++) begin
            check(dq_out, r ? ram_m[4'(a + k)] : flash_m[4'(a + k)]);
            check({15'h0, rdy}, {15'h0, valid_lvl});
            host.pulse();
        end
        host.done();
        burst_mode = 1'b0;
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        seed = 32'hb2226207;
        {rst_b, burst_mode, pol_hi, rst_f_n, wp_n, accel} = 7'b0011101;
        foreach (flash_m[i]) flash_m[i] = 16'hffff;
        foreach (ram_m[i]) ram_m[i] = 16'h0000;
        repeat (4) @(posedge ref_clk);
        #1;
        rst_b = 1'b1;
        host.cyc(4);
        check({10'h0, dq_oe_n, rdy_oe_n, busy, bypass, pwait_hi}, 16'h39);
        verify_all(1'b0);
        $display("test reset and erased read done");
        prog(4'h0, 16'(rnd()));
        check(16'(last_busy), 16'(`PROG_CYCLES));
        for (int k = 0; k < 3; k++) prog(4'h5, 16'(rnd()));
        wp_n = 1'b0;
        foreach (wp_list[i]) prog(wp_list[i], 16'(rnd()));
        wp_n = 1'b1;
        accel = `ACC_VIL;
        prog(4'h7, 16'(rnd()));
        accel = `ACC_VHH;
        host.cyc(4);
        check({15'h0, bypass}, 16'h1);
        prog(4'h6, 16'(rnd()));
        check(16'(last_busy), 16'(`ACCEL_PROG_CYCLES));
        accel = 2'h1;
        verify_all(1'b0);
        $display("test flash program done");
        for (int i = 0; i < 16; i++) begin
            d = 16'(rnd());
            host.write(1'b1, 4'(i), d, 1'b0, 1'b0, 1'b0);
            ram_m[i] = d;
        end
        d = 16'(rnd());
        host.write(1'b1, 4'h2, d, 1'b0, 1'b1, 1'b0);
        ram_m[2][15:8] = d[15:8];
        host.write(1'b1, 4'h9, d, 1'b1, 1'b0, 1'b0);
        ram_m[9][7:0] = d[7:0];
        host.write(1'b1, 4'ha, d, 1'b1, 1'b1, 1'b0);
        verify_all(1'b1);
        $display("test ram byte lanes done");
        burst(1'b0, 4'h3, 1'b1);
        pol_hi = 1'b0;
        burst(1'b0, 4'h3, 1'b0);
        burst(1'b1, 4'h3, 1'b0);
        host.write(1'b1, 4'h0, 16'h0000, 1'b0, 1'b0, 1'b1);
        check({15'h0, pwait_hi}, 16'h0);
        burst(1'b1, 4'h3, 1'b1);
        $display("test burst and polarity done");
        burst_mode = 1'b1;
        host.read(1'b0, 4'h3);
        rst_f_n = 1'b0;
        host.cyc(4);
        check({15'h0, busy}, 16'h0);
        rst_f_n = 1'b1;
        host.done();
        burst_mode = 1'b0;
        verify_all(1'b0);
        $display("test flash reset done");
        close_out();
    end
endmodule // tb
